/* File: logic/sms_sequencer.sv */
// Purpose: Power-on startup sequencer with mode switch bank, diagnosis, scan start and stop handling.
// Assumes: Firmware reports each phase end through the step register; switches are slow pins.
// Notes: Registers are reached over APB with one wait state.
//
// Overview of operation
// - Halt switch on stops the user program; off lets it run.
// - Firmware load switch on at startup enters system load mode.
// - Memory clear switch on at startup clears user memory, then continues.
// - Memory clear switch off loads user programs from flash and runs them.
// - Autoconfig switch on at startup runs self-configuration of option modules.
// - After power-up diagnose RAM, ROM, CPU and FPU in turn.
// - A startup diagnosis failure blinks alarm and fault red, count names item.
// - Run lamp blinks green while self-configuration runs.
// - With halt switch off, run the startup drawing before scanning.
// - First scan starts after the drawing plus one full scan period.
// - System I/O is serviced from the first scan, never during drawing.
// - Motion halts on halt switch, supply loss, fatal error or tool stop.
// - Fatal error holds until power cycle; tool stop ends on tool run.
// - During scans keep diagnosing ROM and RAM in the background.
// - An online diagnosis failure blinks the fault lamp red.
// - Startup failure blink counts: RAM two, ROM three, CPU four, FPU five.
// - Normal online operation lights prepared and run lamps steadily.
`include "sms_consts.svh"
module sms_sequencer
  import sms_pkg::*;
#(
  parameter int BLINK_CYC = `SMS_BLINK_CYC, // Half blink period in cycles
  parameter logic [31:0] SCAN_CYC = `SMS_SCAN_CYC // Default scan period in cycles
) (
  input wire logic I_CLK, // System clock, 100 MHz
  input wire logic I_RSTN, // Power-on reset, active low
  input wire logic [5:0] I_MODE_SWITCH_BANK, // Switch positions 1 to 6, high is on
  input wire logic I_SUPPLY_LOSS, // Supply loss or interruption pin
  input wire logic I_PSEL, // APB select
  input wire logic I_PENABLE, // APB enable
  input wire logic I_PWRITE, // APB direction
  input wire logic [7:0] I_PADDR, // APB byte address
  input wire logic [31:0] I_PWDATA, // APB write data
  output logic [31:0] O_PRDATA, // APB read data
  output logic O_PREADY, // APB ready
  output logic O_PSLVERR, // APB error on unmapped address
  output logic O_RDY_LED, // Prepared lamp
  output logic O_RUN_LED, // Run lamp, green
  output logic O_ALARM_INDICATOR, // Alarm lamp, red
  output logic O_FAULT_LED, // Fault lamp, red
  output logic O_USER_RUN, // User program may execute
  output logic O_MOTION_EN, // Motion control enabled
  output logic O_SYS_IO_EN, // System I/O servicing enabled
  output logic O_SCAN_TICK, // One pulse per scan period
  output logic [3:0] O_PHASE // Current sequencer phase
);

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  logic [6:0] pins;
  sms_switch_s sw_live;
  sms_switch_s sw_strap;
  logic supply_loss;

  sms_sync u_sync (
    .i_clk(I_CLK),
    .i_rstn(I_RSTN),
    .i_pins({I_SUPPLY_LOSS, I_MODE_SWITCH_BANK[5:0]}),
    .o_pins(pins)
  );

  // Position 6 is the halt switch and lands in the top field of the struct.
  assign sw_live = sms_switch_s'(pins[5:0]);
  assign supply_loss = pins[6];

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic access;
  logic wr_stb;
  logic mapped;
  logic ctrl_wr;
  logic step_wr;
  logic [31:0] scan_period;
  logic [31:0] status;

  function automatic logic hits(input logic [7:0] a, input logic [7:0] off);
    hits = (a == off);
  endfunction : hits

  assign access = I_PSEL && I_PENABLE && !O_PREADY;
  assign mapped = hits(I_PADDR, `SMS_ADDR_CTRL) || hits(I_PADDR, `SMS_ADDR_STEP)
               || hits(I_PADDR, `SMS_ADDR_STATUS) || hits(I_PADDR, `SMS_ADDR_SCAN_PERIOD);
  // Writes land at the edge that completes the transfer, while the master still holds it.
  assign wr_stb = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE;
  assign ctrl_wr = wr_stb && hits(I_PADDR, `SMS_ADDR_CTRL);
  assign step_wr = wr_stb && hits(I_PADDR, `SMS_ADDR_STEP);

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_PREADY <= 1'b0;
      O_PSLVERR <= 1'b0;
      O_PRDATA <= 32'h0000_0000;
    end else begin
      O_PREADY <= access;
      O_PSLVERR <= access && !mapped;
      if (access && !I_PWRITE) begin
        if (hits(I_PADDR, `SMS_ADDR_STATUS)) begin
          O_PRDATA <= status;
        end else if (hits(I_PADDR, `SMS_ADDR_SCAN_PERIOD)) begin
          O_PRDATA <= scan_period;
        end else begin
          O_PRDATA <= 32'h0000_0000;
        end
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      scan_period <= SCAN_CYC;
    end else if (wr_stb && hits(I_PADDR, `SMS_ADDR_SCAN_PERIOD) && I_PWDATA != 32'h0000_0000) begin
      scan_period <= I_PWDATA;
    end
  end

  // ----------------------------------------------------------------
  // Step reports from firmware
  // ----------------------------------------------------------------
  logic step_done;
  logic step_fail;

  assign step_done = step_wr && I_PWDATA[`SMS_STEP_DONE_BIT];
  assign step_fail = step_wr && I_PWDATA[`SMS_STEP_FAIL_BIT];

  // ----------------------------------------------------------------
  // Stop causes
  // ----------------------------------------------------------------
  logic fatal;
  logic tool_stop;
  logic supply_lost;
  logic halt_req;

  // Fatal and supply loss never clear short of a new power-on reset.
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      fatal <= 1'b0;
      supply_lost <= 1'b0;
    end else begin
      if (ctrl_wr && I_PWDATA[`SMS_CTRL_FATAL_BIT]) begin
        fatal <= 1'b1;
      end
      if (supply_loss) begin
        supply_lost <= 1'b1;
      end
    end
  end

  // A stop written together with a run wins, so a stop is never lost.
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      tool_stop <= 1'b0;
    end else if (ctrl_wr && I_PWDATA[`SMS_CTRL_STOP_BIT]) begin
      tool_stop <= 1'b1;
    end else if (ctrl_wr && I_PWDATA[`SMS_CTRL_RUN_BIT]) begin
      tool_stop <= 1'b0;
    end
  end

  assign halt_req = sw_live.program_halt || tool_stop || supply_lost;

  // ----------------------------------------------------------------
  // Divided ticks
  // ----------------------------------------------------------------
  logic [31:0] blink_cnt;
  logic blink_tick;
  logic [31:0] scan_cnt;
  logic scan_tick;

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      blink_cnt <= 32'h0000_0000;
      blink_tick <= 1'b0;
    end else begin
      blink_tick <= (blink_cnt == 32'(BLINK_CYC - 1));
      blink_cnt <= (blink_cnt == 32'(BLINK_CYC - 1)) ? 32'h0000_0000 : blink_cnt + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------
  // Phase sequencer
  // ----------------------------------------------------------------
  sms_state_e state;
  sms_state_e next_state;
  logic [1:0] diag_item;
  logic online_item;
  logic online_fault;
  logic [2:0] fail_count;

  function automatic logic [2:0] item_blinks(input logic [1:0] item);
    case (item)
      2'd0: item_blinks = `SMS_BLINK_RAM;
      2'd1: item_blinks = `SMS_BLINK_ROM;
      2'd2: item_blinks = `SMS_BLINK_CPU;
      default: item_blinks = `SMS_BLINK_FPU;
    endcase
  endfunction : item_blinks

  // Scan timer restarts on entry to the wait phase so a full period elapses.
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      scan_cnt <= 32'h0000_0000;
      scan_tick <= 1'b0;
    end else if (state != ST_SCAN_WAIT && state != ST_SCAN) begin
      scan_cnt <= 32'h0000_0000;
      scan_tick <= 1'b0;
    end else begin
      scan_tick <= (scan_cnt >= scan_period - 32'h0000_0001);
      scan_cnt <= (scan_cnt >= scan_period - 32'h0000_0001) ? 32'h0000_0000 : scan_cnt + 32'h0000_0001;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      ST_RESET_IND: begin
        if (blink_tick) begin
          next_state = ST_INIT;
        end
      end
      ST_INIT: next_state = ST_DIAG;
      ST_DIAG: begin
        if (step_fail) begin
          next_state = ST_DIAG_FAIL;
        end else if (step_done && diag_item == 2'd3) begin
          if (sw_strap.firmware_load_switch) begin
            next_state = ST_SYS_LOAD;
          end else if (sw_strap.memory_clear) begin
            next_state = ST_MEM_CLEAR;
          end else begin
            next_state = ST_FLASH_LOAD;
          end
        end
      end
      ST_DIAG_FAIL: next_state = ST_DIAG_FAIL;
      ST_SYS_LOAD: next_state = ST_SYS_LOAD;
      ST_MEM_CLEAR, ST_FLASH_LOAD: begin
        if (step_done) begin
          next_state = sw_strap.autoconfig_switch ? ST_CONFIG : ST_HALT;
        end
      end
      ST_CONFIG: begin
        if (step_done) begin
          next_state = ST_HALT;
        end
      end
      ST_HALT: begin
        if (!halt_req) begin
          next_state = ST_DRAWING;
        end
      end
      ST_DRAWING: begin
        if (halt_req) begin
          next_state = ST_HALT;
        end else if (step_done) begin
          next_state = ST_SCAN_WAIT;
        end
      end
      ST_SCAN_WAIT: begin
        if (halt_req) begin
          next_state = ST_HALT;
        end else if (scan_tick) begin
          next_state = ST_SCAN;
        end
      end
      ST_SCAN: begin
        if (halt_req) begin
          next_state = ST_HALT;
        end
      end
      ST_DOWN: next_state = ST_DOWN;
      default: next_state = ST_INIT;
    endcase
    if (fatal) begin
      next_state = ST_DOWN;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      state <= ST_RESET_IND;
    end else begin
      state <= next_state;
    end
  end

  // The switch bank is captured once as the reset indication ends.
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      sw_strap <= '0;
    end else if (state == ST_INIT) begin
      sw_strap <= sw_live;
      sw_strap.reserved_factory_switch_a <= 1'b0;
      sw_strap.reserved_factory_switch_b <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      diag_item <= 2'd0;
      fail_count <= 3'h0;
    end else if (state == ST_DIAG) begin
      if (step_fail) begin
        fail_count <= item_blinks(diag_item);
      end else if (step_done) begin
        diag_item <= diag_item + 2'd1;
      end
    end else if (state == ST_SCAN && step_fail && !online_fault) begin
      fail_count <= item_blinks({1'b0, !online_item});
    end
  end

  // Background checks alternate ROM and RAM for as long as scans run.
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      online_item <= 1'b0;
      online_fault <= 1'b0;
    end else if (state == ST_SCAN) begin
      if (step_fail) begin
        online_fault <= 1'b1;
      end else if (step_done) begin
        online_item <= !online_item;
      end
    end
  end

  // ----------------------------------------------------------------
  // Indicators
  // ----------------------------------------------------------------
  logic blink_led;
  logic run_blink;
  sms_led_s leds;

  sms_blink u_blink (
    .i_clk(I_CLK),
    .i_rstn(I_RSTN),
    .i_tick(blink_tick),
    .i_en(state == ST_DIAG_FAIL || (state == ST_SCAN && online_fault)),
    .i_count(fail_count),
    .o_led(blink_led)
  );

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      run_blink <= 1'b0;
    end else if (state != ST_CONFIG) begin
      run_blink <= 1'b0;
    end else if (blink_tick) begin
      run_blink <= !run_blink;
    end
  end

  // Lamps follow the phase being entered, so they change at the same edge as O_PHASE.
  always_comb begin
    leds = '0;
    case (next_state)
      ST_RESET_IND: begin
        leds.alarm_indicator = 1'b1;
        leds.fault = 1'b1;
      end
      ST_DIAG_FAIL: begin
        leds.alarm_indicator = blink_led;
        leds.fault = blink_led;
      end
      ST_CONFIG: leds.run = run_blink;
      ST_DRAWING, ST_SCAN_WAIT: leds.run = 1'b1;
      ST_HALT: leds.rdy = 1'b1;
      ST_SCAN: begin
        leds.rdy = 1'b1;
        leds.run = 1'b1;
        leds.fault = blink_led;
      end
      ST_DOWN: leds.fault = 1'b1;
      default: leds = '0;
    endcase
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_RDY_LED <= 1'b0;
      O_RUN_LED <= 1'b0;
      O_ALARM_INDICATOR <= 1'b0;
      O_FAULT_LED <= 1'b0;
      O_USER_RUN <= 1'b0;
      O_MOTION_EN <= 1'b0;
      O_SYS_IO_EN <= 1'b0;
      O_SCAN_TICK <= 1'b0;
      O_PHASE <= 4'h0;
    end else begin
      O_RDY_LED <= leds.rdy;
      O_RUN_LED <= leds.run;
      O_ALARM_INDICATOR <= leds.alarm_indicator;
      O_FAULT_LED <= leds.fault;
      O_USER_RUN <= (next_state == ST_DRAWING || next_state == ST_SCAN_WAIT
                    || next_state == ST_SCAN);
      O_MOTION_EN <= (next_state == ST_SCAN);
      O_SYS_IO_EN <= (next_state == ST_SCAN);
      O_SCAN_TICK <= scan_tick && (state == ST_SCAN_WAIT || state == ST_SCAN) && !halt_req && !fatal;
      O_PHASE <= 4'(next_state);
    end
  end

  assign status = {10'h000, leds, fail_count, online_fault, supply_lost, fatal, tool_stop,
                   sw_live.program_halt, 6'(sw_strap), 4'(state)};

endmodule : sms_sequencer

/* File: inc/sms_consts.svh */
// Purpose: Offsets, fields, reset values and timing counts of the startup mode sequencer.
// Assumes: 100 MHz system clock, APB with 8-bit byte address.
// Notes: Included by bare name; definitions only.
`ifndef SMS_CONSTS_SVH
`define SMS_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SMS_ADDR_CTRL 8'h00
`define SMS_ADDR_STEP 8'h04
`define SMS_ADDR_STATUS 8'h08
`define SMS_ADDR_SCAN_PERIOD 8'h0C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SMS_CTRL_RUN_BIT 0
`define SMS_CTRL_STOP_BIT 1
`define SMS_CTRL_FATAL_BIT 2
`define SMS_STEP_DONE_BIT 0
`define SMS_STEP_FAIL_BIT 1
`define SMS_SW_WIDTH 6
`define SMS_PIN_WIDTH 7

// ----------------------------------------------------------------
// Blink counts per diagnosed item
// ----------------------------------------------------------------
`define SMS_BLINK_RAM 3'h2
`define SMS_BLINK_ROM 3'h3
`define SMS_BLINK_CPU 3'h4
`define SMS_BLINK_FPU 3'h5
`define SMS_BLINK_GAP 4'h4

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SMS_CLK_HZ 100_000_000
`define SMS_BLINK_HALF_MS 250
`define SMS_BLINK_CYC (`SMS_CLK_HZ / 1000 * `SMS_BLINK_HALF_MS)
`define SMS_SCAN_MS 2
`define SMS_SCAN_CYC (`SMS_CLK_HZ / 1000 * `SMS_SCAN_MS)

`endif

/* File: inc/sms_pkg.sv */
// Purpose: Types shared by the startup mode sequencer files.
// Assumes: Nothing beyond the constants header.
// Notes: Switch bank bit order follows the physical positions 1 to 6.
package sms_pkg;

  // ----------------------------------------------------------------
  // Sequencer phases
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_RESET_IND,
    ST_INIT,
    ST_DIAG,
    ST_DIAG_FAIL,
    ST_SYS_LOAD,
    ST_MEM_CLEAR,
    ST_FLASH_LOAD,
    ST_CONFIG,
    ST_HALT,
    ST_DRAWING,
    ST_SCAN_WAIT,
    ST_SCAN,
    ST_DOWN
  } sms_state_e;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic program_halt;
    logic firmware_load_switch;
    logic memory_clear;
    logic autoconfig_switch;
    logic reserved_factory_switch_a;
    logic reserved_factory_switch_b;
  } sms_switch_s;

  typedef struct packed {
    logic rdy;
    logic run;
    logic alarm_indicator;
    logic fault;
  } sms_led_s;

endpackage : sms_pkg

/* File: logic/sms_sync.sv */
// Purpose: Two-flop synchroniser for the switch bank and supply-loss pins.
// Assumes: Pins change slowly compared with the clock.
// Notes: Only the second stage may be read by other logic.
`include "sms_consts.svh"
module sms_sync
  import sms_pkg::*;
(
  input wire logic i_clk, // System clock
  input wire logic i_rstn, // Asynchronous reset, active low
  input wire logic [`SMS_PIN_WIDTH-1:0] i_pins, // Raw pin levels
  output logic [`SMS_PIN_WIDTH-1:0] o_pins // Synchronised levels
);

  logic [`SMS_PIN_WIDTH-1:0] meta;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta <= '0;
      o_pins <= '0;
    end else begin
      meta <= i_pins;
      o_pins <= meta;
    end
  end

endmodule : sms_sync

/* File: logic/sms_blink.sv */
// Purpose: Counted blink pattern generator for an indicator lamp.
// Assumes: i_tick is a one-cycle pulse marking each half blink period.
// Notes: A pattern is count flashes followed by a dark gap, then repeats.
`include "sms_consts.svh"
module sms_blink
  import sms_pkg::*;
(
  input wire logic i_clk, // System clock
  input wire logic i_rstn, // Asynchronous reset, active low
  input wire logic i_tick, // Half-period tick
  input wire logic i_en, // Pattern enable
  input wire logic [2:0] i_count, // Number of flashes
  output logic o_led // Lamp drive
);

  logic [3:0] step;
  logic [3:0] span;

  assign span = {i_count, 1'b0} + `SMS_BLINK_GAP;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      step <= '0;
      o_led <= 1'b0;
    end else if (!i_en) begin
      step <= '0;
      o_led <= 1'b0;
    end else if (i_tick) begin
      step <= (step + 4'h1 >= span) ? 4'h0 : step + 4'h1;
      o_led <= (step < {i_count, 1'b0}) && !step[0];
    end
  end

endmodule : sms_blink

/* File: test/sms_operator.sv */
// Purpose: Operator model: mode switch bank and supply pin.
// Assumes: The bench asks for switch levels.
// Notes: Reserved positions are wired off.
module sms_operator (
  input wire logic [5:0] i_req, // Requested levels
  input wire logic i_loss_req, // Requested supply loss
  output logic [5:0] o_bank, // Switch pins
  output logic o_loss // Supply loss pin
);
  timeunit 1ns;
  timeprecision 100ps;
  // A careful operator never moves the factory positions, whatever is asked.
  assign o_bank = {i_req[5:2], 2'b00};
  assign o_loss = i_loss_req;
endmodule : sms_operator

/* File: test/sms_checker.sv */
// Purpose: Port checks of the startup mode sequencer.
// Assumes: Phase codes are the package enum.
// Notes: Bound to every sequencer instance.
module sms_checker
  import sms_pkg::*;
#(
  parameter int BLINK_CYC = 4 // Half blink period
) (
  input wire logic I_CLK, // Clock
  input wire logic I_RSTN, // Reset, active low
  input wire logic [5:0] I_MODE_SWITCH_BANK, // Switches
  input wire logic I_SUPPLY_LOSS, // Supply loss
  input wire logic I_PSEL, // APB select
  input wire logic I_PENABLE, // APB enable
  input wire logic O_PREADY, // APB ready
  input wire logic O_PSLVERR, // APB error
  input wire logic O_RDY_LED, // Prepared lamp
  input wire logic O_RUN_LED, // Run lamp
  input wire logic O_ALARM_INDICATOR, // Alarm lamp
  input wire logic O_FAULT_LED, // Fault lamp
  input wire logic O_USER_RUN, // User run
  input wire logic O_MOTION_EN, // Motion enable
  input wire logic O_SYS_IO_EN, // System I/O
  input wire logic [3:0] O_PHASE // Phase
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RSTN);
  apb_wait_a: assert property (I_PSEL && I_PENABLE && !O_PREADY |=> O_PREADY)
    else $error("Ready missed its wait state.");
  ready_pulse_a: assert property (O_PREADY |=> !O_PREADY) else $error("Ready stuck high.");
  slverr_ready_a: assert property (O_PSLVERR |-> O_PREADY) else $error("Error without ready.");
  halt_switch_a: assert property (I_MODE_SWITCH_BANK[5] [*4] |-> !O_USER_RUN)
    else $error("User program runs with halt on.");
  supply_halt_a: assert property (I_SUPPLY_LOSS [*5] |-> !O_MOTION_EN)
    else $error("Motion on after supply loss.");
  scan_wait_a: assert property ($rose(O_MOTION_EN) |-> $past(O_PHASE) == ST_SCAN_WAIT)
    else $error("Scan began without a wait period.");
  sysio_scan_a: assert property (O_SYS_IO_EN |-> O_PHASE == ST_SCAN && O_MOTION_EN)
    else $error("System I/O outside scan.");
  drawing_run_a: assert property (O_PHASE == ST_DRAWING |-> O_USER_RUN && !O_SYS_IO_EN)
    else $error("Drawing outputs wrong.");
  online_lamps_a: assert property (O_PHASE == ST_SCAN |-> O_RDY_LED && O_RUN_LED)
    else $error("Online lamps not lit.");
  down_hold_a: assert property (O_PHASE == ST_DOWN |=> O_PHASE == ST_DOWN && !O_MOTION_EN)
    else $error("Left the down phase.");
  diag_blink_a: assert property ($rose(O_PHASE == ST_DIAG_FAIL) |-> ##[1:20] O_ALARM_INDICATOR && O_FAULT_LED)
    else $error("Diagnosis failure lamps dark.");
  cfg_blink_a: assert property (O_PHASE == ST_CONFIG && O_RUN_LED |-> ##[1:8] !O_RUN_LED || O_PHASE != ST_CONFIG)
    else $error("Run lamp not blinking.");
  cover property (O_PHASE == ST_SCAN);
  cover property (O_PHASE == ST_DIAG_FAIL);
  cover property (O_PHASE == ST_CONFIG);
endmodule : sms_checker

bind sms_sequencer sms_checker #(.BLINK_CYC(BLINK_CYC)) i_sms_checker (.I_CLK(I_CLK), .I_RSTN(I_RSTN),
  .I_MODE_SWITCH_BANK(I_MODE_SWITCH_BANK), .I_SUPPLY_LOSS(I_SUPPLY_LOSS), .I_PSEL(I_PSEL),
  .I_PENABLE(I_PENABLE), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_RDY_LED(O_RDY_LED),
  .O_RUN_LED(O_RUN_LED), .O_ALARM_INDICATOR(O_ALARM_INDICATOR), .O_FAULT_LED(O_FAULT_LED),
  .O_USER_RUN(O_USER_RUN), .O_MOTION_EN(O_MOTION_EN), .O_SYS_IO_EN(O_SYS_IO_EN), .O_PHASE(O_PHASE));

/* File: test/test_startup_mode_sequencer.sv */
// Purpose: Self-checking bench of the startup mode sequencer.
// Assumes: Firmware steps are written over APB.
// Notes: Short blink and scan counts keep the run brief.
`include "sms_consts.svh"
module test_startup_mode_sequencer;
  timeunit 1ns;
  timeprecision 100ps;
  import sms_pkg::*;
  typedef struct packed {
    logic [31:0] data;
    logic [31:0] mask;
    logic err;
  } sms_note_s;
  sms_note_s notes[$];
  sms_note_s nt;
  logic clk, rstn, psel, penable, pwrite, loss_req, loss, pready, pslverr, tick;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, seed, sp;
  logic [5:0] sw_req, bank;
  logic [3:0] phase;
  int fail_count, checks;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  localparam logic [31:0] PM = 32'h0000_000F;
  localparam logic [31:0] LM = 32'h003C_000F;

  sms_sequencer #(.BLINK_CYC(4), .SCAN_CYC(32'h0000_0006)) i_sms_sequencer (.I_CLK(clk), .I_RSTN(rstn),
    .I_MODE_SWITCH_BANK(bank), .I_SUPPLY_LOSS(loss), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .O_RDY_LED(), .O_RUN_LED(), .O_ALARM_INDICATOR(), .O_FAULT_LED(), .O_USER_RUN(), .O_MOTION_EN(),
    .O_SYS_IO_EN(), .O_SCAN_TICK(tick), .O_PHASE(phase));
  sms_operator i_sms_operator (.i_req(sw_req), .i_loss_req(loss_req), .o_bank(bank), .o_loss(loss));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xorshift

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Each answer is matched against the oldest expectation noted by the driver.
  always @(posedge clk) begin
    if (pready === 1'b1) begin
      nt = notes.pop_front();
      chk("read data", nt.data, prdata & nt.mask);
      chk("slave error", {31'h0, nt.err}, {31'h0, pslverr});
    end
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e,
                     input logic [31:0] m, input logic er);
    notes.push_back('{e, m, er});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 32'h0, e, m, 1'b0);
  endtask : rd

  task automatic ph(input logic [3:0] p, input logic [3:0] l, input logic [31:0] m);
    rd(`SMS_ADDR_STATUS, {10'h0, l, 14'h0, p}, m);
  endtask : ph

  task automatic step(input logic [1:0] v);
    wr(`SMS_ADDR_STEP, {30'h0, v});
  endtask : step

  task automatic boot(input logic [5:0] s, input int n);
    rstn <= 1'b0;
    sw_req <= s;
    loss_req <= 1'b0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    while (phase !== ST_DIAG) begin
      @(posedge clk);
    end
    repeat (n) step(2'b01);
  endtask : boot

  task automatic wrap_up;
    if (fail_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up

  initial begin
    #100_000;
    fail_count++;
    wrap_up;
  end

  initial begin
    int k;
    {rstn, psel, penable, pwrite, loss_req} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    sw_req = 6'h00;
    fail_count = 0;
    checks = 0;
    seed = xorshift(32'h0000_3330);
    sp = {29'h0, seed[2:0]} + 32'h0000_0003;
    @(posedge clk);
    boot({4'b0011, seed[4:3]}, 0);
    rd(`SMS_ADDR_SCAN_PERIOD, 32'h0000_0006, ALL);
    wr(`SMS_ADDR_SCAN_PERIOD, 32'h0000_0000);
    rd(`SMS_ADDR_SCAN_PERIOD, 32'h0000_0006, ALL);
    wr(`SMS_ADDR_SCAN_PERIOD, sp);
    rd(`SMS_ADDR_SCAN_PERIOD, sp, ALL);
    rd(`SMS_ADDR_CTRL, 32'h0000_0000, ALL);
    apb(1'b0, 8'h10, 32'h0000_0000, 32'h0000_0000, ALL, 1'b1);
    apb(1'b1, 8'h10, ALL, 32'h0000_0000, 32'h0000_0000, 1'b1);
    repeat (4) step(2'b01);
    rd(`SMS_ADDR_STATUS, {22'h0, 6'b001100, 4'h5}, 32'h0000_03FF);
    step(2'b01);
    ph(ST_CONFIG, 4'h0, PM);
    repeat (12) @(posedge clk);
    step(2'b01);
    ph(ST_DRAWING, 4'b0100, LM);
    step(2'b01);
    while (tick !== 1'b1) begin
      @(posedge clk);
    end
    ph(ST_SCAN, 4'b1100, LM);
    step(2'b01);
    step(2'b10);
    rd(`SMS_ADDR_STATUS, 32'h0001_400B, 32'h0003_C00F);
    wr(`SMS_ADDR_CTRL, 32'h0000_0002);
    ph(ST_HALT, 4'h0, PM);
    wr(`SMS_ADDR_CTRL, 32'h0000_0001);
    ph(ST_DRAWING, 4'h0, PM);
    sw_req[5] <= 1'b1;
    repeat (6) @(posedge clk);
    ph(ST_HALT, 4'h0, PM);
    sw_req[5] <= 1'b0;
    repeat (6) @(posedge clk);
    ph(ST_DRAWING, 4'h0, PM);
    loss_req <= 1'b1;
    repeat (6) @(posedge clk);
    loss_req <= 1'b0;
    repeat (6) @(posedge clk);
    ph(ST_HALT, 4'h0, PM);
    wr(`SMS_ADDR_CTRL, 32'h0000_0004);
    ph(ST_DOWN, 4'b0001, LM);
    wr(`SMS_ADDR_CTRL, 32'h0000_0001);
    ph(ST_DOWN, 4'h0, PM);
    boot(6'b010000, 4);
    ph(ST_SYS_LOAD, 4'h0, PM);
    boot(6'b100000, 4);
    ph(ST_FLASH_LOAD, 4'h0, PM);
    step(2'b01);
    ph(ST_HALT, 4'h0, PM);
    for (k = 0; k < 4; k++) begin
      boot(6'h00, k);
      step(2'b10);
      rd(`SMS_ADDR_STATUS, {14'h0, 3'(k + 2), 11'h0, 4'h3}, 32'h0003_800F);
    end
    wrap_up;
  end
endmodule : test_startup_mode_sequencer
